// ===== hw/pstsr_defines.svh
// Offsets, field positions, reset values and test limits of the status block
`ifndef PSTSR_DEFINES_SVH
`define PSTSR_DEFINES_SVH

`define PSTSR_STATUS_OFF   8'h0C
`define PSTSR_CODE_MSB     31
`define PSTSR_CODE_LSB     24
`define PSTSR_ATTACH_BIT   23
`define PSTSR_VSTAT_MSB    22
`define PSTSR_VSTAT_LSB    16
`define PSTSR_SCRATCH_MSB  15
`define PSTSR_STATUS_RST   32'h0000_0000
`define PSTSR_BASE_SELF    7'h00
`define PSTSR_BASE_CPUMEM  7'h3C
`define PSTSR_BASE_ADDMEM  7'h50
`define PSTSR_BASE_MP      7'h5A
`define PSTSR_LAST_NOVEC   7'h2D
`define PSTSR_LAST_VEC     7'h39
`define PSTSR_NODES        16
`define PSTSR_ALL_ONES     16'hFFFF

`endif

// ===== hw/pstsr_elect.sv
// Lowest-identifier picker over the boot candidates
`timescale 1ns/1ps
module pstsr_elect (
  pstsr_elect_if.elector el
);
  logic [16:0] seen;
  logic [15:0] pick;

  assign seen[0] = 1'b0;

  // ----------------------------------------
  // Priority chain, node 0 first
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_node
      assign pick[g]     = el.cand[g] & ~seen[g];
      assign seen[g + 1] = seen[g] | el.cand[g];
    end
  endgenerate

  always_comb begin
    el.node = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (pick[i]) begin
        el.node = 4'(i);
      end
    end
  end

  assign el.found = seen[16];
endmodule

// ===== hw/pstsr_elect_if.sv
// Candidate set and election answer between top and elector
`timescale 1ns/1ps
interface pstsr_elect_if;
  logic [15:0] cand;
  logic        found;
  logic [3:0]  node;

  modport elector (
    input  cand,
    output found,
    output node
  );
  modport owner (
    output cand,
    input  found,
    input  node
  );
endinterface

// ===== hw/pstsr_pkg.sv
// Types shared by the self-test status block
package pstsr_pkg;
  typedef enum logic [1:0] {
    PH_SELF,
    PH_CPUMEM,
    PH_ADDMEM,
    PH_MP
  } pstsr_phase_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_FAIL
  } pstsr_state_t;
endpackage

// ===== hw/pstsr_top.sv
// Self-test status word, progress trace, vector LED and boot election
`timescale 1ns/1ps
`include "pstsr_defines.svh"

module pstsr_top (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ce,
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [31:0]           reg_wdata,
  output logic [31:0]                reg_rdata_q,
  output logic                       reg_ack_q,
  input  wire logic                  test_start,
  input  wire logic                  test_end,
  input  wire logic                  test_ok,
  input  wire pstsr_pkg::pstsr_phase_t test_phase,
  input  wire logic [6:0]            test_num,
  input  wire logic                  vec_attached,
  input  wire logic [6:0]            vec_status,
  output logic                       trace_valid_q,
  output logic [6:0]                 trace_num_q,
  output logic                       seq_done_q,
  output logic                       vec_led_q,
  input  wire logic                  onboard_done,
  input  wire logic                  extended_done,
  input  wire logic [15:0]           node_is_scalar,
  input  wire logic [15:0]           onboard_test_result,
  input  wire logic [15:0]           extended_test_result,
  input  wire logic                  boot_ineligible_command,
  input  wire logic                  vector_disable_command,
  input  wire logic                  cmd_value,
  input  wire logic [3:0]            cmd_node,
  output logic [15:0]                scalar_eligible_q,
  output logic [15:0]                vector_enabled_q,
  output logic [15:0]                onboard_report_q,
  output logic [15:0]                extended_report_q,
  output logic                       boot_valid_q,
  output logic [3:0]                 boot_node_q
);
  import pstsr_pkg::*;

  pstsr_elect_if el ();

  pstsr_state_t st_q;
  logic [31:0]  status_q;
  logic         fail_ev;
  logic         pass_ev;
  logic [6:0]   base;
  logic [6:0]   last_num;
  logic [7:0]   fail_code;

  function automatic logic [7:0] bcd8(input logic [6:0] v);
    logic [3:0] tens;
    logic [3:0] ones;
    tens = 4'(v / 7'd10);
    ones = 4'(v % 7'd10);
    return {tens, ones};
  endfunction

  // ----------------------------------------
  // Failing code formation
  // ----------------------------------------
  always_comb begin
    case (test_phase)
      PH_SELF:   base = `PSTSR_BASE_SELF;
      PH_CPUMEM: base = `PSTSR_BASE_CPUMEM;
      PH_ADDMEM: base = `PSTSR_BASE_ADDMEM;
      PH_MP:     base = `PSTSR_BASE_MP;
      default:   base = `PSTSR_BASE_SELF;
    endcase
  end

  assign fail_code = bcd8(7'(base + test_num));
  assign fail_ev   = ce && test_end && !test_ok && st_q != ST_FAIL;
  assign pass_ev   = ce && test_end && test_ok && st_q != ST_FAIL;
  assign last_num  = vec_attached ? `PSTSR_LAST_VEC : `PSTSR_LAST_NOVEC;

  // ----------------------------------------
  // Test sequence state
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          if (fail_ev) begin
            st_q <= ST_FAIL;
          end else if (test_start) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fail_ev) begin
            st_q <= ST_FAIL;
          end
        end
        ST_FAIL: st_q <= ST_FAIL;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Trace halts for good once a test fails
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trace_valid_q <= 1'b0;
      trace_num_q   <= 7'h00;
    end else if (ce) begin
      trace_valid_q <= test_start && st_q != ST_FAIL && !seq_done_q;
      if (test_start && st_q != ST_FAIL && !seq_done_q) begin
        trace_num_q <= test_num;
      end
    end
  end

  // Short sequence when no vector unit is present
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_done_q <= 1'b0;
    end else if (ce && pass_ev && test_phase == PH_SELF
                 && test_num == last_num) begin
      seq_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      vec_led_q <= 1'b0;
    end else if (ce) begin
      if (fail_ev || !vec_attached) begin
        vec_led_q <= 1'b0;
      end else if (pass_ev && test_phase == PH_SELF
                   && test_num == `PSTSR_LAST_VEC) begin
        vec_led_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Status word and register port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_q <= `PSTSR_STATUS_RST;
    end else if (ce) begin
      if (reg_wr && reg_addr == `PSTSR_STATUS_OFF) begin
        status_q[`PSTSR_CODE_MSB:`PSTSR_CODE_LSB] <=
          reg_wdata[`PSTSR_CODE_MSB:`PSTSR_CODE_LSB];
        status_q[`PSTSR_SCRATCH_MSB:0] <= reg_wdata[`PSTSR_SCRATCH_MSB:0];
      end
      if (fail_ev) begin
        status_q[`PSTSR_CODE_MSB:`PSTSR_CODE_LSB] <= fail_code;
      end
      status_q[`PSTSR_ATTACH_BIT] <= vec_attached;
      status_q[`PSTSR_VSTAT_MSB:`PSTSR_VSTAT_LSB] <= vec_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q   <= 1'b0;
    end else if (ce) begin
      reg_ack_q <= reg_rd || reg_wr;
      if (reg_rd && reg_addr == `PSTSR_STATUS_OFF) begin
        reg_rdata_q <= status_q;
      end else if (reg_rd) begin
        reg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Eligibility, enables and result reports
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scalar_eligible_q <= `PSTSR_ALL_ONES;
      vector_enabled_q  <= `PSTSR_ALL_ONES;
    end else if (ce) begin
      if (boot_ineligible_command) begin
        scalar_eligible_q[cmd_node] <= ~cmd_value;
      end
      if (vector_disable_command) begin
        vector_enabled_q[cmd_node] <= ~cmd_value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      onboard_report_q  <= 16'h0000;
      extended_report_q <= 16'h0000;
    end else if (ce) begin
      if (onboard_done) begin
        onboard_report_q <= onboard_test_result & node_is_scalar;
      end
      if (extended_done) begin
        extended_report_q <= extended_test_result & node_is_scalar;
      end
    end
  end

  // ----------------------------------------
  // Boot election
  // ----------------------------------------
  // Left scalars have higher ids, so lower passing nodes win
  assign el.cand = node_is_scalar & onboard_test_result & scalar_eligible_q
                   & (extended_done ? extended_test_result
                                    : `PSTSR_ALL_ONES);

  pstsr_elect u_elect (
    .el (el.elector)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      boot_valid_q <= 1'b0;
      boot_node_q  <= 4'h0;
    end else if (ce && (onboard_done || extended_done)) begin
      boot_valid_q <= el.found;
      boot_node_q  <= el.node;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_fail_in(pstsr_phase_t ph);
    fail_ev && test_phase == ph;
  endsequence

  sequence s_last_novec;
    pass_ev && !vec_attached && test_phase == PH_SELF
      && test_num == `PSTSR_LAST_NOVEC;
  endsequence

  chk_cpumem_code: assert property (@(posedge clk) disable iff (!reset_n)
    s_fail_in(PH_CPUMEM) |=> status_q[31:24] ==
      bcd8(7'($past(test_num) + 7'd60)))
    else $error("cpu/memory failing code wrong");

  chk_mp_code: assert property (@(posedge clk) disable iff (!reset_n)
    s_fail_in(PH_MP) |=> status_q[31:24] ==
      bcd8(7'($past(test_num) + 7'd90)))
    else $error("multiprocessor failing code wrong");

  chk_self_code: assert property (@(posedge clk) disable iff (!reset_n)
    s_fail_in(PH_SELF) |=> status_q[31:24] == bcd8($past(test_num)))
    else $error("self-test failing code wrong");

  chk_attach_flag: assert property (@(posedge clk) disable iff (!reset_n)
    ce ##1 1'b1 |-> status_q[23] == $past(vec_attached)
      && status_q[22:16] == $past(vec_status))
    else $error("attach flag or vector status stale");

  chk_trace_halt: assert property (@(posedge clk) disable iff (!reset_n)
    st_q == ST_FAIL |=> !trace_valid_q [*2])
    else $error("trace emitted after failure");

  chk_short_seq: assert property (@(posedge clk) disable iff (!reset_n)
    s_last_novec |=> seq_done_q && !vec_led_q)
    else $error("sequence did not end at test 45");

  chk_led_dark: assert property (@(posedge clk) disable iff (!reset_n)
    fail_ev |=> !vec_led_q)
    else $error("vector LED lit after failure");

  chk_status_read: assert property (@(posedge clk) disable iff (!reset_n)
    ce && reg_rd && reg_addr == 8'h0C |=>
      reg_ack_q && reg_rdata_q == $past(status_q))
    else $error("status word read wrong");

  chk_boot_pick: assert property (@(posedge clk) disable iff (!reset_n)
    ce && (onboard_done || extended_done) && el.cand[0] |=>
      boot_valid_q && boot_node_q == 4'h0)
    else $error("node 0 candidate not elected");
endmodule

// ===== verification/pstsr_fw_model.sv
// Test sequencer standing in for the console firmware
`timescale 1ns/1ps
module pstsr_fw_model (
  input  wire logic         clk,
  output logic              start,
  output logic              fin,
  output logic              ok,
  output pstsr_pkg::pstsr_phase_t phase,
  output logic [6:0]        num
);
  import pstsr_pkg::*;
  initial begin
    start = 0;
    fin = 0;
    ok = 1;
    phase = PH_SELF;
    num = 7'h00;
  end
  // One test: start pulse, then end pulse carrying the outcome
  task automatic run(input pstsr_phase_t ph, input [6:0] n, input bit p);
    @(posedge clk);
    #1 start = 1;
    phase = ph;
    num = n;
    @(posedge clk);
    #1 start = 0;
    fin = 1;
    ok = p;
    @(posedge clk);
    #1 fin = 0;
    ok = ~p;
  endtask
endmodule

// ===== verification/pstsr_top_tb.sv
// Self-checking bench for the self-test status block
`timescale 1ns/1ps
module pstsr_top_tb;
  import pstsr_pkg::*;
  logic clk = 0, reset_n = 0, ce = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q, d;
  logic reg_ack_q, test_start, test_end, test_ok, vec_attached = 0;
  pstsr_phase_t test_phase;
  logic [6:0]  test_num, trace_num_q, vec_status = 7'h5A;
  logic trace_valid_q, seq_done_q, vec_led_q, onboard_done = 0;
  logic extended_done = 0, boot_ineligible_command = 0, cmd_value = 0;
  logic vector_disable_command = 0, boot_valid_q;
  logic [3:0]  cmd_node = 4'h0, boot_node_q;
  logic [15:0] node_is_scalar = 16'h0016;
  logic [15:0] onboard_test_result = 16'hFFFF;
  logic [15:0] extended_test_result = 16'hFFFB;
  logic [15:0] scalar_eligible_q, vector_enabled_q;
  logic [15:0] onboard_report_q, extended_report_q;
  int miscompares = 0, n_compared = 0, cyc = 0, n_trace = 0, t0 = 0;
  pstsr_phase_t ph_t[6] = '{PH_SELF, PH_CPUMEM, PH_CPUMEM,
                            PH_ADDMEM, PH_MP, PH_MP};
  logic [6:0] num_t[6] = '{7'h0E, 7'h01, 7'h16, 7'h03, 7'h01, 7'h07};
  logic [7:0] code_t[6] = '{8'h14, 8'h61, 8'h82, 8'h83, 8'h91, 8'h97};

  always #12.5 clk = ~clk;

  pstsr_top u_pstsr_top (.*);
  pstsr_fw_model u_pstsr_fw_model (.clk(clk), .start(test_start),
    .fin(test_end), .ok(test_ok), .phase(test_phase), .num(test_num));

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rst();
    #1 reset_n = 0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
  endtask
  task automatic acc(input bit w, input [7:0] a, input [31:0] v);
    @(posedge clk);
    #1 reg_wr = w;
    reg_rd = ~w;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 0;
    reg_rd = 0;
    chk("ack", reg_ack_q, 32'h1);
    d = reg_rdata_q;
  endtask
  task automatic elect(input bit ext, input [3:0] n);
    @(posedge clk);
    #1 onboard_done = ~ext;
    extended_done = ext;
    @(posedge clk);
    #1 onboard_done = 0;
    extended_done = 0;
    chk("boot", {boot_valid_q, boot_node_q}, {1'b1, n});
  endtask
  task automatic cmd(input bit vec, input [3:0] n);
    @(posedge clk);
    #1 boot_ineligible_command = ~vec;
    vector_disable_command = vec;
    cmd_value = 1;
    cmd_node = n;
    @(posedge clk);
    #1 boot_ineligible_command = 0;
    vector_disable_command = 0;
  endtask
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (trace_valid_q === 1'b1)
      n_trace++;
    if (cyc == 6000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    rst();
    chk("elig", scalar_eligible_q, 32'hFFFF);
    acc(0, 8'h0C, 32'h0);
    chk("status rst", d, 32'h005A0000);
    acc(1, 8'h10, 32'hFFFFFFFF);
    acc(0, 8'h10, 32'h0);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      rst();
      u_pstsr_fw_model.run(ph_t[i], num_t[i], 0);
      acc(0, 8'h0C, 32'h0);
      chk("code", d[31:24], code_t[i]);
      u_pstsr_fw_model.run(PH_MP, 7'h02, 0);
      acc(0, 8'h0C, 32'h0);
      chk("code held", d[31:24], code_t[i]);
      chk("trace", trace_num_q, num_t[i]);
    end
    rst();
    t0 = n_trace;
    for (int n = 1; n <= 45; n++)
      u_pstsr_fw_model.run(PH_SELF, n[6:0], 1);
    chk("done novec", seq_done_q, 32'h1);
    u_pstsr_fw_model.run(PH_SELF, 7'h2E, 1);
    chk("trace end", trace_num_q, 32'h2D);
    chk("trace cnt", n_trace - t0, 32'h2D);
    rst();
    vec_attached = 1;
    acc(1, 8'h0C, 32'hFFFFFFFF);
    acc(0, 8'h0C, 32'h0);
    chk("vec bits", d, 32'hFFDAFFFF);
    for (int n = 1; n <= 57; n++) begin
      u_pstsr_fw_model.run(PH_SELF, n[6:0], 1);
      if (n == 45)
        chk("done vec", seq_done_q, 32'h0);
    end
    chk("led on", vec_led_q, 32'h1);
    u_pstsr_fw_model.run(PH_SELF, 7'h39, 0);
    chk("led off", vec_led_q, 32'h0);
    vec_attached = 0;
    acc(0, 8'h0C, 32'h0);
    chk("detached", d, 32'h575AFFFF);
    elect(0, 4'h1);
    cmd(0, 4'h1);
    cmd(1, 4'h4);
    chk("elig cmd", scalar_eligible_q, 32'hFFFD);
    chk("vec cmd", vector_enabled_q, 32'hFFEF);
    ce = 0;
    cmd(0, 4'h2);
    ce = 1;
    chk("ce hold", scalar_eligible_q, 32'hFFFD);
    elect(0, 4'h2);
    elect(1, 4'h4);
    chk("onb rep", onboard_report_q, 32'h0016);
    chk("ext rep", extended_report_q, 32'h0012);
    node_is_scalar = 16'h0017;
    elect(0, 4'h0);
    close_out();
  end
endmodule
